// file: pkg/core_cfg.svh
// Constants of the 8-bit core: widths, special register map, status bits, reset values.
// Assumes inclusion by bare name; holds definitions only.
`ifndef CORE_CFG_SVH
`define CORE_CFG_SVH
`define INSN_W         12
`define DATA_W         8
`define PC_W           10
`define PHASES         4
`define SFR_INDIRECT   5'h00
`define SFR_PCL        5'h02
`define SFR_STATUS     5'h03
`define SFR_FSR        5'h04
`define ST_C           0
`define ST_DC          1
`define ST_Z           2
`define ST_PAGE        5
`define STATUS_RESET   8'h18
`define STATUS_RO_MASK 8'h18
`define FSR_RESET      8'h00
`define W_RESET        8'h00
`define PC_RESET       10'h3FF
`define INSN_NOP       12'h000
`endif

// file: pkg/core_pkg.sv
// Types shared by the core datapath and its ALU.
// Assumes nothing of its surroundings.
package core_pkg;
  typedef enum logic [1:0] {phase_one, phase_two, phase_three, phase_four} phase_type;
  typedef enum logic [3:0] {
    alu_add, alu_sub, alu_ior, alu_and, alu_xor, alu_pass_f, alu_com, alu_inc,
    alu_dec, alu_rr, alu_rl, alu_swap, alu_clr, alu_pass_a, alu_bclr, alu_bset
  } alu_op_type;
endpackage

// file: src/core_alu.sv
// Combinational 8-bit ALU of the core.
// Assumes operands are stable for the whole phase in which the result is used.
`timescale 1ns/1ps
`default_nettype none
module core_alu (
  input  wire core_pkg::alu_op_type op,
  input  wire logic [7:0]           opa,
  input  wire logic [7:0]           opf,
  input  wire logic                 carry_in,
  input  wire logic [2:0]           bit_sel,
  output logic [7:0]                result,
  output logic                      carry_out,
  output logic                      nibble_out,
  output logic                      zero_out
);
  // Returns {carry out of bit 3, carry out of bit 7, sum}
  function automatic logic [9:0] add8(input logic [7:0] x, input logic [7:0] y,
                                      input logic cin);
    logic [4:0] low;
    logic [8:0] full;
    low  = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, cin};
    full = {1'b0, x} + {1'b0, y} + {8'h00, cin};
    return {low[4], full};
  endfunction

  logic [9:0] sum;

  always_comb begin
    sum        = 10'h000;
    result     = opf;
    carry_out  = carry_in;
    nibble_out = 1'b0;
    case (op)
      core_pkg::alu_add: begin
        sum = add8(opf, opa, 1'b0);
      end
      core_pkg::alu_sub: begin
        // Two's complement: f + ~a + 1, carries read as no-borrow
        sum = add8(opf, ~opa, 1'b1);
      end
      core_pkg::alu_inc: sum = add8(opf, 8'h01, 1'b0);
      core_pkg::alu_dec: sum = add8(opf, 8'hFF, 1'b0);
      default: sum = 10'h000;
    endcase
    case (op)
      core_pkg::alu_add, core_pkg::alu_sub: begin
        result     = sum[7:0];
        carry_out  = sum[8];
        nibble_out = sum[9];
      end
      core_pkg::alu_inc, core_pkg::alu_dec: result = sum[7:0];
      core_pkg::alu_ior:    result = opf | opa;
      core_pkg::alu_and:    result = opf & opa;
      core_pkg::alu_xor:    result = opf ^ opa;
      core_pkg::alu_com:    result = ~opf;
      core_pkg::alu_rr: begin
        result    = {carry_in, opf[7:1]};
        carry_out = opf[0];
      end
      core_pkg::alu_rl: begin
        result    = {opf[6:0], carry_in};
        carry_out = opf[7];
      end
      core_pkg::alu_swap:   result = {opf[3:0], opf[7:4]};
      core_pkg::alu_clr:    result = 8'h00;
      core_pkg::alu_pass_a: result = opa;
      core_pkg::alu_bclr:   result = opf & ~(8'h01 << bit_sel);
      core_pkg::alu_bset:   result = opf | (8'h01 << bit_sel);
      default:              result = opf;
    endcase
  end

  assign zero_out = (result == 8'h00);
endmodule
`default_nettype wire

// file: src/risc_core_datapath.sv
// Fetch/execute datapath of the 8-bit core with 12-bit instructions.
// Assumes program memory answers combinationally and data memory one cycle after data_re.
`timescale 1ns/1ps
`default_nettype none
`include "core_cfg.svh"
module risc_core_datapath (
  input  wire logic               core_clk,
  input  wire logic               nrst,
  output logic [`PC_W-1:0]        prog_addr,
  input  wire logic [`INSN_W-1:0] prog_data,
  output logic [7:0]              data_addr,
  output logic                    data_re,
  output logic                    data_we,
  output logic [`DATA_W-1:0]      data_wdata,
  input  wire logic [`DATA_W-1:0] data_rdata,
  output logic [`DATA_W-1:0]      work_acc,
  output logic [`DATA_W-1:0]      status_flags,
  output logic                    cycle_start
);
  core_pkg::phase_type  ph, next_ph;
  core_pkg::alu_op_type op;
  logic [`PC_W-1:0]   pc, next_pc, stack0, next_stack0, stack1, next_stack1, next_prog_addr;
  logic [`INSN_W-1:0] ir, next_ir;
  logic [7:0]         w, next_w, status, next_status, fsr, next_fsr;
  logic [7:0]         file_val, next_file_val, next_data_addr, next_data_wdata;
  logic [7:0]         eff, rd_val, opa, alu_res;
  logic [4:0]         lo;
  logic               next_data_re, next_data_we, next_cycle_start;
  logic               dest_f, dest_w, fl_c, fl_dc, fl_z, use_lit, jump, call, ret;
  logic               test_clr, test_set, skip_zero, ext, tbit, take_branch;
  logic               alu_c, alu_dc, alu_z;

  // Decode of the latched instruction word
  always_comb begin
    op = core_pkg::alu_pass_f;
    {dest_f, dest_w, fl_c, fl_dc, fl_z, use_lit} = 6'h00;
    {jump, call, ret, test_clr, test_set, skip_zero} = 6'h00;
    if (ir[11:10] == 2'b11) begin
      use_lit = 1'b1;
      dest_w  = 1'b1;
      fl_z    = (ir[9:8] != 2'b00);
      case (ir[9:8])
        2'b00:   op = core_pkg::alu_pass_a;
        2'b01:   op = core_pkg::alu_ior;
        2'b10:   op = core_pkg::alu_and;
        default: op = core_pkg::alu_xor;
      endcase
    end else if (ir[11:9] == 3'b101) begin
      jump = 1'b1;
    end else if (ir[11:8] == 4'h9) begin
      call = 1'b1;
    end else if (ir[11:8] == 4'h8) begin
      ret     = 1'b1;
      use_lit = 1'b1;
      dest_w  = 1'b1;
      op      = core_pkg::alu_pass_a;
    end else if (ir[11:10] == 2'b01) begin
      case (ir[9:8])
        2'b00:   begin op = core_pkg::alu_bclr; dest_f = 1'b1; end
        2'b01:   begin op = core_pkg::alu_bset; dest_f = 1'b1; end
        2'b10:   test_clr = 1'b1;
        default: test_set = 1'b1;
      endcase
    end else if (ir[11:6] == 6'h00) begin
      // Control words other than the accumulator store leave the datapath alone
      op     = core_pkg::alu_pass_a;
      dest_f = ir[5];
    end else if (ir[11:6] == 6'h01) begin
      op     = core_pkg::alu_clr;
      fl_z   = 1'b1;
      dest_f = ir[5];
      dest_w = !ir[5];
    end else begin
      dest_f = ir[5];
      dest_w = !ir[5];
      fl_z   = 1'b1;
      case (ir[9:6])
        4'h2:    begin op = core_pkg::alu_sub; {fl_c, fl_dc} = 2'b11; end
        4'h3:    op = core_pkg::alu_dec;
        4'h4:    op = core_pkg::alu_ior;
        4'h5:    op = core_pkg::alu_and;
        4'h6:    op = core_pkg::alu_xor;
        4'h7:    begin op = core_pkg::alu_add; {fl_c, fl_dc} = 2'b11; end
        4'h8:    op = core_pkg::alu_pass_f;
        4'h9:    op = core_pkg::alu_com;
        4'hA:    op = core_pkg::alu_inc;
        4'hB:    begin op = core_pkg::alu_dec; fl_z = 1'b0; skip_zero = 1'b1; end
        4'hC:    begin op = core_pkg::alu_rr; fl_z = 1'b0; fl_c = 1'b1; end
        4'hD:    begin op = core_pkg::alu_rl; fl_z = 1'b0; fl_c = 1'b1; end
        4'hE:    begin op = core_pkg::alu_swap; fl_z = 1'b0; end
        default: begin op = core_pkg::alu_inc; fl_z = 1'b0; skip_zero = 1'b1; end
      endcase
    end
  end

  // Address zero selects the location held in the pointer register
  assign eff = (ir[4:0] == `SFR_INDIRECT) ? fsr : {fsr[7:5], ir[4:0]};
  assign lo  = eff[4:0];
  assign ext = !(lo == `SFR_INDIRECT || lo == `SFR_PCL || lo == `SFR_STATUS || lo == `SFR_FSR);

  always_comb begin
    if (lo == `SFR_INDIRECT) begin
      rd_val = 8'h00;
    end else if (lo == `SFR_PCL) begin
      // The word after the executing one; pc itself already runs two words ahead
      rd_val = prog_addr[7:0];
    end else if (lo == `SFR_STATUS) begin
      rd_val = status;
    end else if (lo == `SFR_FSR) begin
      rd_val = fsr;
    end else begin
      rd_val = data_rdata;
    end
  end

  assign opa = use_lit ? ir[7:0] : w;

  core_alu u_alu (
    .op         (op),
    .opa        (opa),
    .opf        (file_val),
    .carry_in   (status[`ST_C]),
    .bit_sel    (ir[7:5]),
    .result     (alu_res),
    .carry_out  (alu_c),
    .nibble_out (alu_dc),
    .zero_out   (alu_z)
  );

  assign tbit        = file_val[ir[7:5]];
  assign take_branch = jump || call || ret || (dest_f && lo == `SFR_PCL) ||
                       (test_clr && !tbit) || (test_set && tbit) || (skip_zero && alu_z);

  always_comb begin
    next_ph          = ph;
    next_pc          = pc;
    next_prog_addr   = prog_addr;
    next_ir          = ir;
    next_w           = w;
    next_status      = status;
    next_fsr         = fsr;
    next_stack0      = stack0;
    next_stack1      = stack1;
    next_file_val    = file_val;
    next_data_addr   = data_addr;
    next_data_wdata  = data_wdata;
    next_data_re     = 1'b0;
    next_data_we     = 1'b0;
    next_cycle_start = 1'b0;
    case (ph)
      core_pkg::phase_one: begin
        next_ph        = core_pkg::phase_two;
        next_prog_addr = pc;
        next_pc        = pc + 10'h001;
        next_data_addr = eff;
        next_data_re   = ext;
      end
      core_pkg::phase_two: begin
        next_ph = core_pkg::phase_three;
      end
      core_pkg::phase_three: begin
        next_ph       = core_pkg::phase_four;
        next_file_val = rd_val;
      end
      default: begin
        next_ph          = core_pkg::phase_one;
        next_cycle_start = 1'b1;
        if (dest_w) begin
          next_w = alu_res;
        end
        if (dest_f && ext) begin
          next_data_we    = 1'b1;
          next_data_wdata = alu_res;
        end
        if (dest_f && lo == `SFR_FSR) begin
          next_fsr = alu_res;
        end
        if (dest_f && lo == `SFR_STATUS) begin
          next_status = (alu_res & ~`STATUS_RO_MASK) | (status & `STATUS_RO_MASK);
        end
        // Flag results overrule a plain write aimed at the status register
        if (fl_c) begin
          next_status[`ST_C] = alu_c;
        end
        if (fl_dc) begin
          next_status[`ST_DC] = alu_dc;
        end
        if (fl_z) begin
          next_status[`ST_Z] = alu_z;
        end
        next_ir = take_branch ? `INSN_NOP : prog_data;
        if (jump) begin
          next_pc = {status[`ST_PAGE], ir[8:0]};
        end else if (call) begin
          next_pc     = {status[`ST_PAGE], 1'b0, ir[7:0]};
          // Return to the word after the call, not to pc, which is two words ahead
          next_stack0 = prog_addr;
          next_stack1 = stack0;
        end else if (ret) begin
          next_pc     = stack0;
          next_stack0 = stack1;
        end else if (dest_f && lo == `SFR_PCL) begin
          next_pc = {status[`ST_PAGE], 1'b0, alu_res};
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ph          <= core_pkg::phase_one;
      pc          <= `PC_RESET;
      prog_addr   <= `PC_RESET;
      ir          <= `INSN_NOP;
      w           <= `W_RESET;
      status      <= `STATUS_RESET;
      fsr         <= `FSR_RESET;
      stack0      <= `PC_RESET;
      stack1      <= `PC_RESET;
      file_val    <= 8'h00;
      data_addr   <= 8'h00;
      data_wdata  <= 8'h00;
      data_re     <= 1'b0;
      data_we     <= 1'b0;
      cycle_start <= 1'b1;
    end else begin
      ph          <= next_ph;
      pc          <= next_pc;
      prog_addr   <= next_prog_addr;
      ir          <= next_ir;
      w           <= next_w;
      status      <= next_status;
      fsr         <= next_fsr;
      stack0      <= next_stack0;
      stack1      <= next_stack1;
      file_val    <= next_file_val;
      data_addr   <= next_data_addr;
      data_wdata  <= next_data_wdata;
      data_re     <= next_data_re;
      data_we     <= next_data_we;
      cycle_start <= next_cycle_start;
    end
  end

  assign work_acc     = w;
  assign status_flags = status;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  a_phase_cycle_len: assert property ((ph == core_pkg::phase_one) |-> ##4 (ph == core_pkg::phase_one))
    else $error("instruction cycle is not four phases");
  a_pc_step_one: assert property ((ph == core_pkg::phase_one) |=> (pc == $past(pc) + 10'h001))
    else $error("pc did not step in phase_one");
  a_fetch_addr_hold: assert property ((ph == core_pkg::phase_one) |=> (prog_addr == $past(pc)))
    else $error("fetch address differs from pc");
  a_ir_latch_four: assert property ((ph != core_pkg::phase_four) |=> $stable(ir))
    else $error("instruction register moved outside phase_four");
  a_branch_flush_nop: assert property ((ph == core_pkg::phase_four && take_branch) |=> (ir == `INSN_NOP))
    else $error("fetched word kept after branch");
  a_acc_write_four: assert property ((ph != core_pkg::phase_four) |=> $stable(w))
    else $error("accumulator changed outside phase_four");
  a_data_we_window: assert property (data_we |-> (ph == core_pkg::phase_one && !data_re))
    else $error("data write outside its window");
  a_zero_flag_set: assert property ((ph == core_pkg::phase_four && fl_z) |=> (status[`ST_Z] == ($past(alu_res) == 8'h00)))
    else $error("zero flag wrong");
  a_sub_no_borrow: assert property ((ph == core_pkg::phase_four && op == core_pkg::alu_sub) |=> (status[`ST_C] == ($past(file_val) >= $past(w))))
    else $error("subtract carry is not no-borrow");
  a_call_push_ret: assert property ((ph == core_pkg::phase_four && call) |=> (stack0 == $past(prog_addr) && pc[7:0] == $past(ir[7:0])))
    else $error("call did not push return address");

  c_branch_taken: cover property (ph == core_pkg::phase_four && take_branch);
  c_sub_borrow: cover property (ph == core_pkg::phase_four && op == core_pkg::alu_sub && !alu_c);
  c_indirect_read: cover property (data_re && ir[4:0] == `SFR_INDIRECT);
  c_call_then_ret: cover property ((ph == core_pkg::phase_four && call) ##[4:40] (ph == core_pkg::phase_four && ret));
endmodule
`default_nettype wire

// file: bench/core_mem_model.sv
// Program memory and data memory across the core's two buses.
// Assumes the core samples read data one edge after its read pulse.
`timescale 1ns/1ps
`default_nettype none
`include "core_cfg.svh"
module core_mem_model (
  input  wire logic               core_clk,
  input  wire logic               nrst,
  input  wire logic [`PC_W-1:0]   prog_addr,
  output logic [`INSN_W-1:0]      prog_data,
  input  wire logic [7:0]         data_addr,
  input  wire logic               data_re,
  input  wire logic               data_we,
  input  wire logic [`DATA_W-1:0] data_wdata,
  output logic [`DATA_W-1:0]      data_rdata
);
  logic [`INSN_W-1:0] prog [0:1023];
  logic [`DATA_W-1:0] dmem [0:255];

  initial begin
    for (int i = 0; i < 1024; i++) begin
      prog[i] = `INSN_NOP;
    end
    for (int i = 0; i < 256; i++) begin
      dmem[i] = 8'h00;
    end
  end

  // One whole word per address, answered at once
  assign prog_data = prog[prog_addr];

  // Read byte lives for the sampling cycle only; inverted after, so stale data never looks fresh
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      data_rdata <= 8'h00;
    end else if (data_re) begin
      data_rdata <= dmem[data_addr];
    end else begin
      data_rdata <= ~data_rdata;
    end
  end

  always @(posedge core_clk) begin
    if (nrst && data_we) begin
      dmem[data_addr] <= data_wdata;
    end
  end
endmodule
`default_nettype wire

// file: bench/tb_top.sv
// Bench for the core datapath: short programs with random and corner operands.
// Assumes the memory model in core_mem_model.sv on both buses.
`timescale 1ns/1ps
`default_nettype none
`include "core_cfg.svh"
module tb_top;
  logic                 core_clk;
  logic                 nrst;
  logic [`PC_W-1:0]     prog_addr;
  logic [`INSN_W-1:0]   prog_data;
  logic [7:0]           data_addr;
  logic                 data_re;
  logic                 data_we;
  logic [`DATA_W-1:0]   data_wdata;
  logic [`DATA_W-1:0]   data_rdata;
  logic [`DATA_W-1:0]   work_acc;
  logic [`DATA_W-1:0]   status_flags;
  logic                 cycle_start;
  int                   fail_count;
  int                   total_checks;
  int                   seed;
  int                   edges;
  int                   starts;
  // Opcode patterns; operand bits are ORed in
  localparam logic [11:0] op_movlw = 12'hC00;
  localparam logic [11:0] op_addwf = 12'h1C0;
  localparam logic [11:0] op_subwf = 12'h080;
  localparam logic [11:0] op_movwf = 12'h020;
  localparam logic [11:0] op_goto  = 12'hA00;
  localparam logic [11:0] op_movf  = 12'h200;
  localparam logic [11:0] op_call  = 12'h900;
  localparam logic [11:0] op_retlw = 12'h800;

  risc_core_datapath i_dut (.core_clk(core_clk), .nrst(nrst), .prog_addr(prog_addr),
    .prog_data(prog_data), .data_addr(data_addr), .data_re(data_re), .data_we(data_we),
    .data_wdata(data_wdata), .data_rdata(data_rdata), .work_acc(work_acc),
    .status_flags(status_flags), .cycle_start(cycle_start));
  core_mem_model i_mem (.core_clk(core_clk), .nrst(nrst), .prog_addr(prog_addr),
    .prog_data(prog_data), .data_addr(data_addr), .data_re(data_re), .data_we(data_we),
    .data_wdata(data_wdata), .data_rdata(data_rdata));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    if (!nrst) begin
      edges <= 0;
      starts <= 0;
    end else begin
      edges <= edges + 1;
      starts <= starts + int'(cycle_start);
    end
  end

  function automatic logic [7:0] add_st(input logic [7:0] x, input logic [7:0] y);
    logic [8:0] t;
    logic [4:0] n;
    t = {1'b0, x} + {1'b0, y};
    n = {1'b0, x[3:0]} + {1'b0, y[3:0]};
    add_st = {5'h03, t[7:0] == 8'h00, n[4], t[8]};
  endfunction

  // Set carry means no borrow
  function automatic logic [7:0] sub_st(input logic [7:0] x, input logic [7:0] y);
    sub_st = {5'h03, x == y, x[3:0] >= y[3:0], x >= y};
  endfunction

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_addr(input logic [9:0] got, input logic [9:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic at_edge(input int n);
    while (edges < n) begin
      @(posedge core_clk);
      #1;
    end
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Reset is released by a clock edge, so the first counted edge is the one after it
  task automatic restart;
    @(posedge core_clk);
    nrst <= 1'b0;
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    #1;
  endtask

  // Program: movlw 12h; movwf pointer; movf through pointer,w; call 10h; movwf 13h; goto 4
  task automatic run_branch(input logic [7:0] k, input logic [7:0] f);
    i_mem.prog[10'h3FF] = op_movlw | 12'h012;
    i_mem.prog[10'h000] = op_movwf | 12'h004;
    i_mem.prog[10'h001] = op_movf;
    i_mem.prog[10'h002] = op_call | 12'h010;
    i_mem.prog[10'h003] = op_movwf | 12'h013;
    i_mem.prog[10'h004] = op_goto | 12'h004;
    i_mem.prog[10'h010] = op_retlw | {4'h0, k};
    i_mem.dmem[8'h12] = f;
    i_mem.dmem[8'h13] = ~k;
    restart();
    at_edge(16);
    chk_byte(work_acc, f, "indirect read");
    chk_byte(status_flags, {5'h03, f == 8'h00, 2'b00}, "move flags");
    at_edge(21);
    chk_addr(prog_addr, 10'h010, "call target");
    at_edge(28);
    chk_byte(work_acc, k, "return literal");
    at_edge(29);
    chk_addr(prog_addr, 10'h003, "return address");
    at_edge(40);
    chk_byte(i_mem.dmem[8'h13], k, "stored after return");
  endtask

  // Program: movlw a; addwf 10h,w; movwf 11h; movlw b; subwf 11h,w; goto 8; movlw EEh
  task automatic run_trial(input logic [7:0] a, input logic [7:0] f, input logic [7:0] b);
    logic [7:0] s;
    s = a + f;
    i_mem.prog[10'h3FF] = op_movlw | {4'h0, a};
    i_mem.prog[10'h000] = op_addwf | 12'h010;
    i_mem.prog[10'h001] = op_movwf | 12'h011;
    i_mem.prog[10'h002] = op_movlw | {4'h0, b};
    i_mem.prog[10'h003] = op_subwf | 12'h011;
    i_mem.prog[10'h004] = op_goto | 12'h008;
    i_mem.prog[10'h005] = op_movlw | 12'h0EE;
    i_mem.prog[10'h008] = op_goto | 12'h008;
    i_mem.dmem[8'h10] = f;
    i_mem.dmem[8'h11] = ~s;
    restart();
    chk_byte(status_flags, `STATUS_RESET, "status reset");
    at_edge(1);
    chk_addr(prog_addr, `PC_RESET, "reset vector");
    at_edge(5);
    chk_addr(prog_addr, 10'h000, "pc step");
    at_edge(8);
    chk_byte(work_acc, a, "immediate load");
    at_edge(12);
    chk_byte(work_acc, s, "add result");
    chk_byte(status_flags, add_st(a, f), "add flags");
    at_edge(20);
    chk_byte(i_mem.dmem[8'h11], s, "stored byte");
    chk_byte(status_flags, add_st(a, f), "flags kept");
    at_edge(24);
    chk_byte(work_acc, s - b, "sub result");
    chk_byte(status_flags, sub_st(s, b), "sub flags");
    at_edge(25);
    chk_addr(prog_addr, 10'h005, "overlapped fetch");
    at_edge(29);
    chk_addr(prog_addr, 10'h008, "branch target");
    at_edge(32);
    chk_byte(work_acc, s - b, "flushed word");
    at_edge(40);
    chk_byte(starts[7:0], 8'h0A, "phase count");
  endtask

  initial begin
    nrst = 1'b0;
    fail_count = 0;
    total_checks = 0;
    seed = 30745;
    repeat (2) @(posedge core_clk);
    run_trial(8'h00, 8'h00, 8'h00);
    run_trial(8'h01, 8'hFF, 8'h01);
    run_trial(8'h0F, 8'h01, 8'h11);
    run_trial(8'h80, 8'h80, 8'h00);
    run_trial(8'h7F, 8'h01, 8'hFF);
    run_branch(8'h5A, 8'h00);
    for (int i = 0; i < 24; i++) begin
      run_trial(8'($random(seed)), 8'($random(seed)), 8'($random(seed)));
      run_branch(8'($random(seed)), 8'($random(seed)));
    end
    summarize();
  end

  // Whole run is near 3300 cycles; far longer means a hang
  initial begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    $display("[ERR] %0t run did not finish", $time);
    summarize();
  end
endmodule
`default_nettype wire
